//--- smib_pkg.sv
// Shared constants, encodings and address helpers for the SDRAM mode/burst core
package smib_pkg;

  // Array geometry: four banks of 4096 rows by 256 columns of 16 bits
  localparam int BANK_W = 2;
  localparam int ROW_W = 12;
  localparam int COL_W = 8;
  localparam int DATA_W = 16;
  localparam int MEM_W = BANK_W + ROW_W + COL_W;
  localparam int NUM_BANKS = 4;

  // Operating configuration register and its field positions
  localparam int MODE_W = 14;
  localparam logic [MODE_W-1:0] MODE_RESET = 14'h0000;
  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam int BT_BIT = 3;
  localparam int LAT_LSB = 4;
  localparam int LAT_MSB = 6;
  localparam int OPM_LSB = 7;
  localparam int OPM_MSB = 8;
  localparam int RSV_LSB = 9;
  localparam int RSV_MSB = 13;

  // Burst length codes
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;

  // Read latency codes
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;

  // Commands as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_ACTIVE = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_BURST_STOP = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;

  // Address line that selects all banks on a precharge
  localparam int PRE_ALL_BIT = 10;

  // Write buffer depth
  localparam int WR_FIFO_DEPTH = 4;

  // Constants at column width
  localparam logic [COL_W-1:0] COL_ZERO = 8'h00;
  localparam logic [COL_W-1:0] COL_ONE = 8'h01;
  localparam logic [COL_W-1:0] COL_LAST_2 = 8'h01;
  localparam logic [COL_W-1:0] COL_LAST_4 = 8'h03;
  localparam logic [COL_W-1:0] COL_LAST_8 = 8'h07;
  localparam logic [COL_W-1:0] COL_LAST_PAGE = 8'hff;

  // Burst engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } smib_burst_t;

  // Last beat index of a burst, also the wrap mask of its column block
  function automatic logic [COL_W-1:0] burst_last(input logic [2:0] code);
    case (code)
      BL_2: burst_last = COL_LAST_2;
      BL_4: burst_last = COL_LAST_4;
      BL_8: burst_last = COL_LAST_8;
      BL_PAGE: burst_last = COL_LAST_PAGE;
      default: burst_last = COL_ZERO;
    endcase
  endfunction

  // Column of beat idx: block bits kept, low bits count or xor within the block
  function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0] start, input logic [COL_W-1:0] idx,
                                                input logic [COL_W-1:0] mask, input logic interleave);
    logic [COL_W-1:0] low;
    low = interleave ? (start ^ idx) : COL_W'(start + idx);
    beat_col = (start & ~mask) | (low & mask);
  endfunction

  // Flat array index of one location
  function automatic logic [MEM_W-1:0] mem_index(input logic [BANK_W-1:0] bank, input logic [ROW_W-1:0] row,
                                                 input logic [COL_W-1:0] col);
    mem_index = {bank, row, col};
  endfunction

endpackage

//--- smib_fifo.sv
// Small flop-based FIFO with valid/ready on both sides
`timescale 1ns/100ps
module smib_fifo #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  logic [WIDTH-1:0] slot_reg [0:DEPTH-1];
  logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic push, pop;

  // Honest full and empty straight from the occupancy count
  assign in_ready = (count_reg != CNT_FULL);
  assign out_valid = (count_reg != '0);
  assign out_data = slot_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == PTR_LAST) ? '0 : PTR_W'(wr_ptr_reg + 1'b1);
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == PTR_LAST) ? '0 : PTR_W'(rd_ptr_reg + 1'b1);
    end
    if (push && !pop) begin
      count_next = CNT_W'(count_reg + CNT_ONE);
    end else if (pop && !push) begin
      count_next = CNT_W'(count_reg - CNT_ONE);
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // Storage; contents need no reset since count guards them
  always_ff @(posedge clk) begin
    if (push) begin
      slot_reg[wr_ptr_reg] <= in_data;
    end
  end
endmodule // smib_fifo

//--- smib_sdram_core.sv
// SDRAM device core: mode register, burst addressing, read latency and array
`timescale 1ns/100ps
// Operation
// RULE_01: all pins are sampled on the rising edge of the one clock.
// RULE_02: four banks, 4096 rows, 256 columns, sixteen-bit locations.
// RULE_03: ACTIVE opens a row; bank pins pick bank, twelve address lines pick row.
// RULE_04: READ or WRITE take the low eight address lines as start column.
// RULE_05: controller waits 100 us with only inhibit or NOP after power-up.
// RULE_06: then controller precharges all banks after at least one NOP.
// RULE_07: controller then runs two auto refreshes before loading the mode.
// RULE_08: mode value is unknown at power-up; load it before operating.
// RULE_09: only LOAD MODE writes the mode; it holds until reloaded.
// RULE_10: bits 0-2 length, 3 order, 4-6 latency, 7-8 mode, 9-13 reserved.
// RULE_11: controller loads the mode with banks idle and waits afterwards.
// RULE_12: lengths 1, 2, 4, 8 in both orders; full page sequential only.
// RULE_13: full-page burst runs until BURST TERMINATE stops it.
// RULE_14: fixed bursts wrap inside the aligned block picked by upper column bits.
// RULE_15: sequential adds beat index, interleaved xors it, within the block.
// RULE_16: full page counts up through the row and wraps to column zero.
// RULE_17: read latency is two or three clocks.
// RULE_18: data pins drive from edge n+m-1, data valid by edge n+m.
// RULE_19: controller picks the latency that suits its clock rate.
// RULE_20: operating mode zero is normal; other codes are not to be used.
// RULE_21: the programmed length applies to reads and writes alike.
// RULE_22: controller avoids reserved length, latency and test-mode codes.
// RULE_23: controller waits two clocks after LOAD MODE before ACTIVE or REFRESH.
// RULE_24: after the first element, one read element per clock.
// RULE_25: controller writes zero to the reserved upper mode bits.
// RULE_26: controller rounds its start-up and command intervals up to clocks.
module smib_sdram_core import smib_pkg::*; #(
  parameter int FIFO_DEPTH = WR_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command pins
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ROW_W-1:0] addr,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  // Data pins
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  // Write buffer back-pressure
  output logic wr_buf_ready
);
  localparam int ENTRY_W = MEM_W + DATA_W;

  // Decoded command, sampled on the rising edge
  logic [3:0] cmd;
  logic [BANK_W-1:0] bank_in;
  logic cmd_load, cmd_active, cmd_read, cmd_write, cmd_stop, cmd_pre;
  assign cmd = {cs_n, ras_n, cas_n, we_n}; // RULE_01
  assign bank_in = {bank_select_high, bank_select_low};
  // Inhibit matches no command code, so it acts as a NOP
  assign cmd_load = (cmd == CMD_LOAD_MODE);
  assign cmd_active = (cmd == CMD_ACTIVE);
  assign cmd_read = (cmd == CMD_READ);
  assign cmd_write = (cmd == CMD_WRITE);
  assign cmd_stop = (cmd == CMD_BURST_STOP);
  assign cmd_pre = (cmd == CMD_PRECHARGE);

  // Operating configuration register state
  logic [MODE_W-1:0] mode_reg, mode_next;

  // Only the load command writes the register; it holds otherwise
  always_comb begin
    mode_next = mode_reg;
    if (cmd_load) begin
      // Operating mode and reserved bits are stored as written and never decoded
      mode_next = {bank_select_high, bank_select_low, addr}; // RULE_09 RULE_08 RULE_20
    end
  end

  // Mode register; reset only gives a known start, power-up content is unknown
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= MODE_RESET; // RULE_08
    end else begin
      mode_reg <= mode_next; // RULE_09
    end
  end

  // Fields of the register; reserved upper field and operating mode kept but unused
  logic [2:0] burst_length_field;
  logic burst_order_bit;
  logic [2:0] read_latency_field;
  logic is_page, interleave, lat_three;
  logic [COL_W-1:0] last_beat;
  assign burst_length_field = mode_reg[BL_MSB:BL_LSB]; // RULE_10
  assign burst_order_bit = mode_reg[BT_BIT]; // RULE_10
  assign read_latency_field = mode_reg[LAT_MSB:LAT_LSB]; // RULE_10
  assign is_page = (burst_length_field == BL_PAGE);
  // Full page never interleaves; the order bit is ignored there
  assign interleave = burst_order_bit && !is_page; // RULE_12
  // Reserved latency codes fall back to three, the slower and safer case
  assign lat_three = (read_latency_field != LAT_2); // RULE_17
  // Reserved length codes fall to a single beat
  assign last_beat = burst_last(burst_length_field); // RULE_12 RULE_21

  // Open row per bank
  logic [ROW_W-1:0] open_row_reg [0:NUM_BANKS-1];
  logic [ROW_W-1:0] open_row_next [0:NUM_BANKS-1];

  // ACTIVE latches the row of the selected bank
  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      open_row_next[b] = open_row_reg[b];
    end
    if (cmd_active) begin
      open_row_next[bank_in] = addr; // RULE_03
    end
  end

  // Open row registers; a row stays until the next ACTIVE to its bank
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Zero rows only so that the model starts known
      for (int b = 0; b < NUM_BANKS; b++) begin
        open_row_reg[b] <= '0;
      end
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        open_row_reg[b] <= open_row_next[b];
      end
    end
  end

  // Burst engine state
  smib_burst_t state_reg, state_next;
  logic [BANK_W-1:0] burst_bank_reg, burst_bank_next;
  logic [ROW_W-1:0] burst_row_reg, burst_row_next;
  logic [COL_W-1:0] start_col_reg, start_col_next;
  logic [COL_W-1:0] beat_reg, beat_next;
  logic pre_hits_burst;
  logic beat_done;
  logic [COL_W-1:0] cur_col;
  logic [COL_W-1:0] cmd_col;

  // Precharge of the burst's bank or of all banks ends the burst
  assign pre_hits_burst = cmd_pre && (addr[PRE_ALL_BIT] || bank_in == burst_bank_reg);
  // Fixed bursts end on their last beat; full page wraps forever
  assign beat_done = !is_page && (beat_reg == last_beat); // RULE_13 RULE_16
  // Column of the current beat, wrapped inside its block
  assign cur_col = beat_col(start_col_reg, beat_reg, last_beat, interleave); // RULE_14 RULE_15 RULE_16
  assign cmd_col = addr[COL_W-1:0]; // RULE_04

  // Next burst state; a new READ or WRITE truncates the running burst
  always_comb begin
    state_next = state_reg;
    burst_bank_next = burst_bank_reg;
    burst_row_next = burst_row_reg;
    start_col_next = start_col_reg;
    beat_next = beat_reg;
    if (cmd_read) begin
      state_next = ST_READ;
      burst_bank_next = bank_in;
      burst_row_next = open_row_reg[bank_in]; // RULE_03
      start_col_next = cmd_col; // RULE_04
      beat_next = COL_ZERO;
    end else if (cmd_write) begin
      // Beat zero is taken with the command itself
      state_next = (last_beat == COL_ZERO) ? ST_IDLE : ST_WRITE; // RULE_21
      burst_bank_next = bank_in;
      burst_row_next = open_row_reg[bank_in];
      start_col_next = cmd_col; // RULE_04
      beat_next = COL_ONE;
    end else if (cmd_stop || pre_hits_burst) begin
      // Issue stops here; read data already in the pipe still leaves
      state_next = ST_IDLE; // RULE_13
      beat_next = COL_ZERO;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          beat_next = COL_ZERO;
        end
        ST_READ, ST_WRITE: begin
          if (beat_done) begin
            state_next = ST_IDLE;
            beat_next = COL_ZERO;
          end else begin
            beat_next = COL_W'(beat_reg + COL_ONE); // RULE_16 RULE_24
          end
        end
        default: begin
          state_next = ST_IDLE;
          beat_next = COL_ZERO;
        end
      endcase
    end
  end

  // Burst engine registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle after reset; a burst needs a new READ or WRITE
      state_reg <= ST_IDLE;
      burst_bank_reg <= '0;
      burst_row_reg <= '0;
      start_col_reg <= COL_ZERO;
      beat_reg <= COL_ZERO;
    end else begin
      state_reg <= state_next;
      burst_bank_reg <= burst_bank_next;
      burst_row_reg <= burst_row_next;
      start_col_reg <= start_col_next;
      beat_reg <= beat_next;
    end
  end

  // Array, one flat index per location
  logic [DATA_W-1:0] mem_reg [0:(1 << MEM_W)-1]; // RULE_02
  logic rd_issue;
  logic [DATA_W-1:0] rd_word;
  assign rd_issue = (state_reg == ST_READ);
  // Array word of the current beat, taken in the issue cycle
  assign rd_word = mem_reg[mem_index(burst_bank_reg, burst_row_reg, cur_col)]; // RULE_15

  // Write beats into the buffer: command beat, then one per clock
  logic wr_push;
  logic [ENTRY_W-1:0] wr_entry;
  logic drain_valid, drain_ready;
  logic [ENTRY_W-1:0] drain_entry;
  always_comb begin
    wr_push = 1'b0;
    wr_entry = '0;
    if (cmd_write) begin
      wr_push = 1'b1;
      wr_entry = {mem_index(bank_in, open_row_reg[bank_in], cmd_col), dq_in}; // RULE_04
    end else if (state_reg == ST_WRITE && !cmd_read && !cmd_stop && !pre_hits_burst) begin
      wr_push = 1'b1;
      wr_entry = {mem_index(burst_bank_reg, burst_row_reg, cur_col), dq_in}; // RULE_15 RULE_21
    end
  end

  // Single array port: read beats win, so writes wait in the buffer
  // Limitation: a read just after a write may return the old word
  assign drain_ready = !rd_issue;

  // Buffer holds write beats while read beats own the array port
  smib_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(wr_push),
    .in_ready(wr_buf_ready),
    .in_data(wr_entry),
    .out_valid(drain_valid),
    .out_ready(drain_ready),
    .out_data(drain_entry)
  );

  // Read latency pipeline: the extra stage is used only at latency three
  logic [DATA_W-1:0] pipe_data_reg, pipe_data_next;
  logic pipe_valid_reg, pipe_valid_next;
  logic [DATA_W-1:0] dq_out_reg, dq_out_next;
  logic dq_oe_reg, dq_oe_next;

  // Latency two bypasses the extra stage; both paths end in the pin flops
  // A WRITE releases the data pins at once and drops queued read data
  always_comb begin
    pipe_data_next = rd_word;
    pipe_valid_next = rd_issue && lat_three; // RULE_17
    dq_out_next = lat_three ? pipe_data_reg : rd_word; // RULE_18
    dq_oe_next = lat_three ? pipe_valid_reg : rd_issue; // RULE_18 RULE_24
    if (cmd_write) begin
      pipe_valid_next = 1'b0;
      dq_oe_next = 1'b0;
    end
  end

  assign dq_out = dq_out_reg;
  assign dq_oe = dq_oe_reg;

  // Read pipeline and pin registers
  // Pins reset released, so nothing drives the data bus after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pipe_data_reg <= '0;
      pipe_valid_reg <= 1'b0;
      dq_out_reg <= '0;
      dq_oe_reg <= 1'b0;
    end else begin
      pipe_data_reg <= pipe_data_next;
      pipe_valid_reg <= pipe_valid_next;
      dq_out_reg <= dq_out_next;
      dq_oe_reg <= dq_oe_next;
    end
  end

  // Array write from the buffer; storage contents are not reset
  always_ff @(posedge clk) begin
    if (drain_valid && drain_ready) begin
      mem_reg[drain_entry[ENTRY_W-1:DATA_W]] <= drain_entry[DATA_W-1:0];
    end
  end
endmodule // smib_sdram_core

//--- smib_sdram_core_asserts.sv
// Concurrent checks on the SDRAM core's pins
`timescale 1ns/100ps
module smib_sdram_core_asserts import smib_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Command pins
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [ROW_W-1:0] addr,
  // Data side
  input wire logic dq_oe,
  input wire logic wr_buf_ready
);
  logic [3:0] cmd;
  logic rd, wr, nop, stop;
  logic [2:0] bl_reg, bl_next, lat_reg, lat_next;
  // Decoded commands; inhibit counts as a no-op
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign rd = cmd == CMD_READ;
  assign wr = cmd == CMD_WRITE;
  assign stop = cmd == CMD_BURST_STOP;
  assign nop = cs_n || cmd == CMD_NOP;
  // Shadow of length and latency; reserved latency codes behave as three
  always_comb begin
    bl_next = bl_reg;
    lat_next = lat_reg;
    if (cmd == CMD_LOAD_MODE) begin
      bl_next = addr[BL_MSB:BL_LSB];
      lat_next = (addr[LAT_MSB:LAT_LSB] == LAT_2) ? LAT_2 : LAT_3;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bl_reg <= BL_1;
      lat_reg <= LAT_3;
    end else begin
      bl_reg <= bl_next;
      lat_reg <= lat_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  reset_quiet_a: assert property ($rose(rst_n) |-> !dq_oe && wr_buf_ready)
    else $error("outputs not quiet after reset");
  lat2_first_a: assert property (rd && lat_reg == LAT_2 ##1 !wr |-> ##1 dq_oe)
    else $error("latency two read did not drive");
  lat3_first_a: assert property (nop[*2] ##1 (rd && lat_reg == LAT_3 && !dq_oe) ##1 nop[*2]
    |-> !dq_oe ##1 dq_oe)
    else $error("latency three read timing wrong");
  rise_cause_a: assert property ($rose(dq_oe) |-> ((lat_reg == LAT_2) ? $past(rd, 2) : $past(rd, 3)))
    else $error("data pins driven without read");
  len4_run_a: assert property (rd && bl_reg == BL_4 && lat_reg == LAT_2 ##1 nop[*6]
    |-> !dq_oe && $past(dq_oe) && $past(dq_oe, 4))
    else $error("length four burst wrong size");
  len1_run_a: assert property (rd && bl_reg == BL_1 && lat_reg == LAT_3 ##1 nop[*4] |-> !dq_oe && $past(dq_oe))
    else $error("length one burst wrong size");
  write_drop_a: assert property (wr |=> !dq_oe)
    else $error("write did not release data pins");
  page_hold_a: assert property (nop[*3] ##0 (bl_reg == BL_PAGE && dq_oe) |=> dq_oe)
    else $error("full page burst stopped early");
  stop_end_a: assert property (stop ##1 nop[*3] |-> !dq_oe)
    else $error("burst ran past terminate");
endmodule // smib_sdram_core_asserts

bind smib_sdram_core smib_sdram_core_asserts u_asserts (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .ras_n(ras_n),
  .cas_n(cas_n), .we_n(we_n), .addr(addr), .dq_oe(dq_oe), .wr_buf_ready(wr_buf_ready));

//--- smib_ctrl_model.sv
// Behavioural memory controller driving the core's command and data pins
`timescale 1ns/100ps
module smib_ctrl_model import smib_pkg::*; #(
  parameter int INIT_NOPS = 1000
) (
  // Clock
  input wire logic clk,
  // Command pins
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [ROW_W-1:0] addr,
  output logic bank_select_low,
  output logic bank_select_high,
  // Write data
  output logic [DATA_W-1:0] dq_in
);
  // Inhibit until the first command
  initial begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    addr = 12'h000;
    {bank_select_high, bank_select_low} = 2'h0;
    dq_in = 16'h0000;
  end
  // One command per clock, launched just after the rising edge
  task automatic op(input logic [3:0] c, input logic [1:0] b = 2'h0, input logic [ROW_W-1:0] a = 12'h000,
                    input logic [DATA_W-1:0] d = 16'hxxxx);
    @(posedge clk);
    #1;
    {cs_n, ras_n, cas_n, we_n} = c;
    {bank_select_high, bank_select_low} = b;
    addr = a;
    dq_in = $isunknown(d) ? ~dq_in : d; // Undriven line must not hold stale data
  endtask
  // Start-up: 100 us of no-ops at 100 ns, precharge all, two refreshes
  task automatic start_up();
    repeat (INIT_NOPS) op(CMD_NOP);
    op(CMD_PRECHARGE, 2'h0, 12'h400);
    op(CMD_NOP);
    op(CMD_REFRESH);
    op(CMD_NOP);
    op(CMD_REFRESH);
    op(CMD_NOP);
  endtask
  // Mode load with all banks closed; reserved and test bits stay zero
  task automatic load_mode(input logic [2:0] len, input logic il, input logic [2:0] lat);
    op(CMD_PRECHARGE, 2'h0, 12'h400);
    op(CMD_NOP);
    op(CMD_LOAD_MODE, 2'h0, {3'h0, 2'h0, lat, il, len});
    op(CMD_NOP);
    op(CMD_NOP);
  endtask
endmodule // smib_ctrl_model

//--- smib_sdram_core_bench.sv
// Self-checking bench for the SDRAM mode and burst core
`timescale 1ns/100ps
module smib_sdram_core_bench import smib_pkg::*;;
  localparam logic [1:0] BANK = 2'h1;
  localparam logic [ROW_W-1:0] ROW = 12'h3c5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high, dq_oe, wr_buf_ready;
  logic [ROW_W-1:0] addr;
  logic [DATA_W-1:0] dq_in, dq_out;
  int n_mismatch = 0;
  int comparisons = 0;
  int cur_len, cur_lat;
  bit cur_il;
  // 10 MHz system clock
  always #50 clk = ~clk;
  smib_ctrl_model u_ctrl (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .addr(addr),
    .bank_select_low(bank_select_low), .bank_select_high(bank_select_high), .dq_in(dq_in));
  smib_sdram_core #(.FIFO_DEPTH(WR_FIFO_DEPTH)) DUT (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .addr(addr), .bank_select_low(bank_select_low),
    .bank_select_high(bank_select_high), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .wr_buf_ready(wr_buf_ready));
  // Compare and count
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Data of a column: both bytes tie it to its address
  function automatic logic [DATA_W-1:0] pat(input logic [COL_W-1:0] col);
    return {~col, col};
  endfunction
  // Column of beat k from block base and offset inside the block
  function automatic logic [COL_W-1:0] col_of(input logic [COL_W-1:0] s, input int k);
    int off;
    off = cur_il ? ((s % cur_len) ^ k) : ((s % cur_len + k) % cur_len);
    return COL_W'((s / cur_len) * cur_len + off);
  endfunction
  // Reload the mode, then reopen the test row
  task automatic mode(input logic [2:0] code, input bit il, input logic [2:0] lat);
    u_ctrl.load_mode(code, il, lat);
    u_ctrl.op(CMD_ACTIVE, BANK, ROW);
    u_ctrl.op(CMD_NOP);
    u_ctrl.op(CMD_NOP);
    cur_len = (code == BL_PAGE) ? 256 : (1 << code);
    cur_il = il;
    cur_lat = (lat == LAT_2) ? 2 : 3;
  endtask
  // Write burst: each beat carries the data of the column it lands on
  task automatic wr_burst(input logic [COL_W-1:0] s);
    for (int k = 0; k < cur_len; k++)
      u_ctrl.op(k == 0 ? CMD_WRITE : CMD_NOP, BANK, {4'h0, s}, pat(col_of(s, k)));
    repeat (6) u_ctrl.op(CMD_NOP); // Single-ported array: let the buffer drain first
  endtask
  // Read burst; a full page is cut short after the wanted beats
  task automatic rd_burst(input logic [COL_W-1:0] s, input int beats);
    int last;
    last = (beats < cur_len) ? beats - 1 : beats;
    u_ctrl.op(CMD_READ, BANK, {4'h0, s});
    for (int k = 1 - cur_lat; k <= last; k++) begin
      u_ctrl.op(CMD_NOP);
      check({15'h0, dq_oe}, 16'(k >= 0 && k < cur_len));
      if (k >= 0 && k < cur_len) check(dq_out, pat(col_of(s, k)));
    end
    if (beats < cur_len) u_ctrl.op(CMD_BURST_STOP);
    repeat (3) u_ctrl.op(CMD_NOP);
    check({15'h0, dq_oe}, 16'h0000);
  endtask
  // Verdict and end of run
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence; latency two is legal at this clock rate
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    u_ctrl.start_up();
    mode(BL_8, 1'b0, LAT_2);
    wr_burst(8'h05);
    rd_burst(8'h05, 8);
    mode(BL_4, 1'b1, LAT_2);
    wr_burst(8'hfd);
    rd_burst(8'h06, 4);
    mode(BL_8, 1'b1, LAT_3);
    rd_burst(8'h05, 8);
    mode(BL_2, 1'b0, LAT_3);
    rd_burst(8'hff, 2);
    mode(BL_2, 1'b1, LAT_2);
    rd_burst(8'h01, 2);
    mode(BL_1, 1'b0, LAT_2);
    rd_burst(8'h03, 1);
    mode(BL_PAGE, 1'b0, LAT_2);
    rd_burst(8'hfc, 6);
    // A write cuts a running read short
    mode(BL_8, 1'b0, LAT_2);
    u_ctrl.op(CMD_READ, BANK, 12'h000);
    u_ctrl.op(CMD_NOP);
    u_ctrl.op(CMD_WRITE, BANK, 12'h010, pat(8'h10));
    check({15'h0, dq_oe}, 16'h0001);
    u_ctrl.op(CMD_NOP);
    check({15'h0, dq_oe}, 16'h0000);
    repeat (12) u_ctrl.op(CMD_NOP);
    // Reset mid-run: mode back to length one, latency three; array kept
    rst_n = 1'b0;
    repeat (2) u_ctrl.op(CMD_NOP);
    rst_n = 1'b1;
    check({15'h0, dq_oe}, 16'h0000);
    u_ctrl.op(CMD_ACTIVE, BANK, ROW);
    u_ctrl.op(CMD_NOP);
    u_ctrl.op(CMD_NOP);
    cur_len = 1;
    cur_il = 1'b0;
    cur_lat = 3;
    rd_burst(8'h02, 1);
    report_and_stop();
  end
endmodule // smib_sdram_core_bench
